// *** rtl/host_bus_port.v ***
// How it works
// - nonmux: with select and write strobe low, read pin high reads, low writes
// - nonmux: write strobe low marks any active cycle, read or write
// - mux: read strobe low while host reads
// - mux: write strobe low while host writes
// - transfers happen only while chip select is low
// - bus lines: data in nonmux, shared address and data in mux
// - register-select lines give address in nonmux, ignored in mux
// - interrupt output low while any interrupt condition is active
// - auxiliary interrupt input is an extra interrupt source
// - card presence inputs high mean a card is inserted
// - start nonmux, rising latch strobe enters mux at any select, reset or deselect with no rise leaves
// - mux: falling latch strobe captures address from low bus lines, any select
`timescale 1ns/100ps
`default_nettype none
`include "host_port_consts.vh"
module host_bus_port #(
  parameter BUS_W = `BUS_W,
  parameter ADDR_W = `ADDR_W
) (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // host bus pins
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire ale,
  input wire [ADDR_W-1:0] reg_sel_lines,
  input wire [BUS_W-1:0] host_bus_lines_in,
  output reg [BUS_W-1:0] host_bus_lines_out,
  output reg host_bus_lines_oe,
  // interrupt and presence pins
  input wire aux_irq_in,
  input wire card_a_present,
  input wire card_b_present,
  output reg int_n,
  // core side: interrupt sources
  input wire core_irq,
  // core side: register access
  output reg [ADDR_W-1:0] reg_addr_r,
  output reg [BUS_W-1:0] wr_data_r,
  output reg wr_stb_r,
  output reg rd_stb_r,
  input wire [BUS_W-1:0] rd_data,
  output reg mux_mode_r,
  output reg aux_irq_r,
  output reg card_a_in_r,
  output reg card_b_in_r
);
  localparam NPIN = `CTL_PINS + ADDR_W + BUS_W;
  // strobes and chip select rest high, latch strobe high, the rest low
  localparam [NPIN-1:0] PIN_RST = {`PIN_CTL_RST, {(ADDR_W + BUS_W){1'b0}}};

  wire [NPIN-1:0] pins_raw;
  wire [NPIN-1:0] pins;
  wire cs_s;
  wire rd_s;
  wire wr_s;
  wire ale_s;
  wire aux_s;
  wire pa_s;
  wire pb_s;
  wire [ADDR_W-1:0] sel_s;
  wire [BUS_W-1:0] bus_s;
  reg ale_d_r;
  reg [ADDR_W-1:0] mux_addr_r;
  reg [1:0] cyc_r;
  reg [1:0] cyc_nxt;
  reg mode_nxt;
  wire ale_rise;
  wire ale_fall;
  wire rd_act;
  wire wr_act;
  wire [ADDR_W-1:0] cur_addr;

  assign pins_raw = {cs_n, rd_n, wr_n, ale, aux_irq_in, card_a_present, card_b_present,
                     reg_sel_lines, host_bus_lines_in};

  pin_sync #(
    .W(NPIN),
    .RST_VAL(PIN_RST)
  ) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in(pins_raw),
    .level_r(pins)
  );

  assign cs_s = pins[NPIN-1];
  assign rd_s = pins[NPIN-2];
  assign wr_s = pins[NPIN-3];
  assign ale_s = pins[NPIN-4];
  assign aux_s = pins[NPIN-5];
  assign pa_s = pins[NPIN-6];
  assign pb_s = pins[NPIN-7];
  assign sel_s = pins[ADDR_W+BUS_W-1:BUS_W];
  assign bus_s = pins[BUS_W-1:0];

  assign ale_rise = ale_s & ~ale_d_r;
  assign ale_fall = ~ale_s & ale_d_r;

  // decode a pending transfer from the synced strobes
  function xfer_req;
    input sel_lvl_n;
    input rd_lvl_n;
    input wr_lvl_n;
    input mux;
    input want_rd;
    begin
      if (sel_lvl_n) begin
        xfer_req = 1'b0;
      end else if (mux) begin
        xfer_req = want_rd ? ~rd_lvl_n : ~wr_lvl_n;
      end else begin
        xfer_req = ~wr_lvl_n & (want_rd ? rd_lvl_n : ~rd_lvl_n);
      end
    end
  endfunction

  // mode select: mux strobes vs nonmux direction pin
  assign rd_act = xfer_req(cs_s, rd_s, wr_s, mux_mode_r, 1'b1);
  assign wr_act = xfer_req(cs_s, rd_s, wr_s, mux_mode_r, 1'b0);
  assign cur_addr = mux_mode_r ? mux_addr_r : sel_s;

  always @* begin
    mode_nxt = mux_mode_r;
    if (cs_s) begin
      mode_nxt = `MODE_NONMUX;
    end else if (ale_rise) begin
      mode_nxt = `MODE_MUX;
    end
    if (ale_rise & cs_s) begin
      mode_nxt = `MODE_MUX;
    end
  end

  always @* begin
    cyc_nxt = cyc_r;
    case (cyc_r)
      `CYC_IDLE: begin
        if (rd_act) begin
          cyc_nxt = `CYC_READ;
        end else if (wr_act) begin
          cyc_nxt = `CYC_WRITE;
        end
      end
      `CYC_READ: begin
        if (!rd_act) begin
          cyc_nxt = `CYC_IDLE;
        end
      end
      `CYC_WRITE: begin
        if (!wr_act) begin
          cyc_nxt = `CYC_IDLE;
        end
      end
      default: begin
        cyc_nxt = `CYC_IDLE;
      end
    endcase
  end

  // latch strobe history matches the synced reset level, so no false rise
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ale_d_r <= `ALE_IDLE;
      mux_mode_r <= `MODE_NONMUX;
    end else begin
      ale_d_r <= ale_s;
      mux_mode_r <= mode_nxt;
    end
  end

  // multiplexed address latch, open in any chip select state
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mux_addr_r <= `ADDR_RST;
    end else if (ale_fall) begin
      mux_addr_r <= bus_s[`ADDR_MSB:`ADDR_LSB];
    end
  end

  // bus cycle tracker
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cyc_r <= `CYC_IDLE;
    end else begin
      cyc_r <= cyc_nxt;
    end
  end

  // core side strobes, address and write data
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_addr_r <= `ADDR_RST;
      wr_data_r <= `BYTE_RST;
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
    end else begin
      rd_stb_r <= (cyc_r == `CYC_IDLE) & rd_act;
      wr_stb_r <= (cyc_r == `CYC_WRITE) & ~wr_act; // write taken at end of strobe
      if (cyc_r == `CYC_IDLE) begin
        reg_addr_r <= cur_addr;
      end
      if (cyc_r == `CYC_WRITE) begin
        wr_data_r <= bus_s;
      end
    end
  end

  // bus drive, only while a selected read stands
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      host_bus_lines_out <= `BYTE_RST;
      host_bus_lines_oe <= 1'b0;
    end else begin
      host_bus_lines_oe <= rd_act;
      host_bus_lines_out <= rd_act ? rd_data : `BYTE_RST;
    end
  end

  // interrupt and card presence levels
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      int_n <= 1'b1;
      aux_irq_r <= 1'b0;
      card_a_in_r <= 1'b0;
      card_b_in_r <= 1'b0;
    end else begin
      aux_irq_r <= aux_s;
      card_a_in_r <= pa_s;
      card_b_in_r <= pb_s;
      int_n <= ~(core_irq | aux_s);
    end
  end
endmodule
`default_nettype wire

// *** rtl/host_port_consts.vh ***
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH
`define BUS_W 8
`define CTL_PINS 7
`define PIN_CTL_RST 7'h78
`define ALE_IDLE 1'b1
`define ADDR_W 4
`define ADDR_LSB 0
`define ADDR_MSB 3
`define SYNC_RST 3'h0
`define BYTE_RST 8'h00
`define ADDR_RST 4'h0
`define MODE_NONMUX 1'b0
`define MODE_MUX 1'b1
`define CYC_IDLE 2'h0
`define CYC_READ 2'h1
`define CYC_WRITE 2'h2
`endif

// *** rtl/pin_sync.v ***
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // raw pins
  input wire [W-1:0] pin_in,
  // filtered level
  output reg [W-1:0] level_r
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  wire [W-1:0] agree;
  // a bit changes once the second and third stages agree
  assign agree = ~(s2_r ^ s3_r);
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      level_r <= RST_VAL;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= (agree & s3_r) | (~agree & level_r);
    end
  end
endmodule
`default_nettype wire

// *** verification/host_bus_port_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_bus_port_checker(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // pins
  input wire logic cs_n,
  input wire logic ale,
  input wire logic aux_irq_in,
  input wire logic card_a_present,
  input wire logic card_b_present,
  input wire logic host_bus_lines_oe,
  input wire logic [7:0] host_bus_lines_out,
  input wire logic int_n,
  // core side
  input wire logic core_irq,
  input wire logic [7:0] rd_data,
  input wire logic rd_stb_r,
  input wire logic wr_stb_r,
  input wire logic mux_mode_r,
  input wire logic aux_irq_r,
  input wire logic card_a_in_r,
  input wire logic card_b_in_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_INT_ON: assert property (core_irq || aux_irq_r |-> ##[0:2] !int_n) else $error("int not low");
  AST_INT_OFF: assert property ((!core_irq && !aux_irq_r)[*3] |-> int_n) else $error("int stuck");
  AST_RD_OE: assert property (rd_stb_r |-> host_bus_lines_oe ##1 !rd_stb_r) else $error("read drive");
  AST_NO_DRIVE: assert property (cs_n[*7] |-> !host_bus_lines_oe && !rd_stb_r && !wr_stb_r) else $error("unselected");
  AST_OUT: assert property (host_bus_lines_oe |-> host_bus_lines_out == $past(rd_data)) else $error("read data");
  AST_MUX_IN: assert property ($rose(ale) |-> ##[1:6] mux_mode_r) else $error("no mux");
  AST_MUX_OUT: assert property ((cs_n && !ale)[*7] |-> !mux_mode_r) else $error("mux kept");
  AST_PINS: assert property ($stable({aux_irq_in, card_a_present, card_b_present})[*6]
    |-> {aux_irq_r, card_a_in_r, card_b_in_r} == {aux_irq_in, card_a_present, card_b_present}) else $error("pins");
  cover property (rd_stb_r && mux_mode_r);
  cover property (wr_stb_r && !mux_mode_r);
  cover property (mux_mode_r ##1 !mux_mode_r);
endmodule
bind host_bus_port host_bus_port_checker u_chk(
  .core_clk(core_clk),
  .nrst(nrst),
  .cs_n(cs_n),
  .ale(ale),
  .aux_irq_in(aux_irq_in),
  .card_a_present(card_a_present),
  .card_b_present(card_b_present),
  .host_bus_lines_oe(host_bus_lines_oe),
  .host_bus_lines_out(host_bus_lines_out),
  .int_n(int_n),
  .core_irq(core_irq),
  .rd_data(rd_data),
  .rd_stb_r(rd_stb_r),
  .wr_stb_r(wr_stb_r),
  .mux_mode_r(mux_mode_r),
  .aux_irq_r(aux_irq_r),
  .card_a_in_r(card_a_in_r),
  .card_b_in_r(card_b_in_r)
);
`default_nettype wire

// *** verification/host_mcu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_mcu_model(
  // clock
  input wire logic core_clk,
  // host pins
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic ale,
  output logic [3:0] reg_sel_lines,
  // bus level and device drive
  output wire logic [7:0] host_bus_lines_in,
  input wire logic [7:0] host_bus_lines_out,
  input wire logic host_bus_lines_oe
);
  logic hen = 0;
  logic [7:0] hd = 8'h00;
  initial {cs_n, rd_n, wr_n, ale, reg_sel_lines} = 8'hE0;
  // released bus shows the inverse of the last value
  assign host_bus_lines_in = host_bus_lines_oe ? host_bus_lines_out : hen ? hd : ~hd;
  task w(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task xfer(input m, r, s, input [3:0] a, input [7:0] d, output [7:0] q);
    reg_sel_lines = m ? 4'hF : a;
    rd_n = m | r;
    w(1);
    cs_n = !s;
    if (m) begin
      hd = {4'h0, a};
      hen = 1;
      ale = 1;
      w(6);
      ale = 0;
      w(6);
    end
    hd = d;
    hen = !r;
    if (m && r) rd_n = 0;
    else wr_n = 0;
    w(8);
    q = host_bus_lines_in;
    wr_n = 1;
    rd_n = 1;
    w(6);
    cs_n = 1;
    hen = 0;
    w(8);
  endtask
endmodule
`default_nettype wire

// *** verification/smart_card_host_bus_port_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module smart_card_host_bus_port_test;
  logic core_clk = 0, nrst = 0, aux_irq_in = 0, card_a_present = 0, card_b_present = 0, core_irq = 0;
  logic [7:0] rd_data = 8'h00, lfsr = 8'h17, ed, q;
  logic [3:0] ea;
  logic em = 0;
  logic [11:0] ex;
  logic [11:0] exp_q[$];
  wire cs_n, rd_n, wr_n, ale, host_bus_lines_oe, int_n, rd_stb_r, wr_stb_r, mux_mode_r, aux_irq_r, card_a_in_r, card_b_in_r;
  wire [3:0] reg_sel_lines, reg_addr_r;
  wire [7:0] host_bus_lines_in, host_bus_lines_out, wr_data_r;
  int n_fail = 0, total_checks = 0, cyc = 0, n_wr = 0, n_rd = 0;
  host_bus_port DUT(.*);
  host_mcu_model host(.*);
  always #25 core_clk = ~core_clk;
  function [7:0] nx(input [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (wr_stb_r) begin
      n_wr++;
      ex = (exp_q.size() > 0) ? exp_q.pop_front() : 12'hFFF;
      `CHK(wr_data_r, ex[7:0])
      `CHK(reg_addr_r, ex[11:8])
      `CHK(mux_mode_r, em)
    end
    if (rd_stb_r) begin n_rd++; `CHK(reg_addr_r, ea) `CHK(mux_mode_r, em) end
    cyc++;
    if (cyc > 5000) begin n_fail++; tally_and_finish; end
  end
  task t(input m, r, s);
    lfsr = nx(lfsr);
    ea = lfsr[3:0];
    ed = nx(lfsr);
    rd_data = ed;
    n_wr = 0;
    n_rd = 0;
    em = m;
    if (s & !r) exp_q.push_back({ea, ed});
    host.xfer(m, r, s, ea, ed, q);
    `CHK(exp_q.size(), 0)
    exp_q.delete();
    `CHK(n_wr, s & !r)
    `CHK(n_rd, s & r)
    if (s & r) `CHK(q, ed)
    $display("transfer mux=%0d read=%0d sel=%0d done", m, r, s);
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    #2 nrst = 1;
    for (int i = 0; i < 16; i++) t(i[2], i[1], i[0]);
    repeat (6) begin
      lfsr = nx(lfsr);
      {aux_irq_in, card_a_present, card_b_present, core_irq} = lfsr[3:0];
      repeat (8) @(posedge core_clk);
      #2;
      `CHK({aux_irq_r, card_a_in_r, card_b_in_r, int_n}, {lfsr[3:1], !(lfsr[3] | lfsr[0])})
    end
    $display("pin test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
